// file: dv/bus_host.sv
// Processor-side bus master model that drives the SRAM control pins
`timescale 1ns/10ps

module bus_host
  import sram_ctrl_pkg::*;
(
  input  wire logic         clk,
  output logic [HIGH_W-1:0] addr_high,
  output logic              addr_low_bit1,
  output logic              addr_low_bit0,
  output logic              processor_addr_strobe_n,
  output logic              controller_addr_strobe_n,
  output logic              burst_advance_n,
  output logic              chip_sel_first_n,
  output logic              chip_sel_second,
  output logic              chip_sel_third_n,
  output logic [LANES-1:0]  byte_lane_select_n,
  output logic              byte_write_enable_n,
  output logic              all_bytes_write_n,
  output logic [DATA_W-1:0] data_in,
  output logic [LANES-1:0]  data_io_parity_in
);
  // Raised only by the scenario that sends lane selects without their qualifier
  logic drop_byte_enable = 1'h0;

  // ------------------------------------------------------------
  // Bus cycle: ctl is {proc strobe, ctrl strobe, advance, global write}, active high
  // ------------------------------------------------------------
  task automatic put(input logic [3:0] ctl, input logic [LANES-1:0] ln, input logic [2:0] sel,
                     input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = ~ctl[3:1];
    all_bytes_write_n = ~ctl[0];
    byte_lane_select_n = ln;
    byte_write_enable_n = (ln == LANES_ALL) | drop_byte_enable;
    {chip_sel_first_n, chip_sel_second, chip_sel_third_n} = sel;
    {addr_high, addr_low_bit1, addr_low_bit0} = a;
    data_in = d;
    data_io_parity_in = ~d[LANES-1:0];
  endtask

  // Changes land on the falling edge so every rising edge sees settled pins
  task automatic op(input logic [3:0] ctl, input logic [LANES-1:0] ln, input logic [2:0] sel,
                    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    put(ctl, ln, sel, a, d);
  endtask

  initial put(4'h0, LANES_ALL, 3'h2, '0, '0);
endmodule

// file: dv/pipelined_burst_sram_control_bench.sv
// Self-checking bench for the pipelined burst SRAM control block
`timescale 1ns/10ps

module pipelined_burst_sram_control_bench
  import sram_ctrl_pkg::*;
;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [2:0]        SEL_OK  = 3'h2;
  localparam logic [2:0]        SEL_BAD = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_A  = 18'h00010;
  localparam logic [ADDR_W-1:0] ADDR_B  = 18'h00100;

  logic              clk               = 1'h0;
  logic              reset_n           = 1'h0;
  logic              third_sel_present = 1'h1;
  logic              output_enable_n   = 1'h0;
  logic              sleep_request     = 1'h0;
  logic              burst_order_strap = 1'h1;
  logic [HIGH_W-1:0] addr_high;
  logic [LANES-1:0]  byte_lane_select_n, data_io_parity_in, data_io_parity_out;
  logic [DATA_W-1:0] data_in, data_out;
  logic              addr_low_bit1, addr_low_bit0, processor_addr_strobe_n;
  logic              controller_addr_strobe_n, burst_advance_n, chip_sel_first_n;
  logic              chip_sel_second, chip_sel_third_n, byte_write_enable_n;
  logic              all_bytes_write_n, data_oe, sleep_active, burst_active;
  int                fails             = 0;
  int                n_tests           = 0;

  always #2.5 clk = ~clk;

  bus_host bus_host_i
  (
    .clk, .addr_high, .addr_low_bit1, .addr_low_bit0, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .burst_advance_n, .chip_sel_first_n, .chip_sel_second,
    .chip_sel_third_n, .byte_lane_select_n, .byte_write_enable_n, .all_bytes_write_n,
    .data_in, .data_io_parity_in
  );

  pipelined_burst_sram_control pipelined_burst_sram_control_i
  (
    .clk, .reset_n, .addr_high, .addr_low_bit1, .addr_low_bit0, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .burst_advance_n, .chip_sel_first_n, .chip_sel_second,
    .chip_sel_third_n, .third_sel_present, .byte_lane_select_n, .byte_write_enable_n,
    .all_bytes_write_n, .output_enable_n, .sleep_request, .burst_order_strap, .data_in,
    .data_io_parity_in, .data_out, .data_io_parity_out, .data_oe, .sleep_active,
    .burst_active
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [WORD_W-1:0] word_of(input logic [DATA_W-1:0] d);
    return {~d[LANES-1:0], d};
  endfunction

  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Data shows one edge after the accept, so the check waits out that edge
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] exp);
    bus_host_i.op(4'h8, LANES_ALL, SEL_OK, a, DATA_RESET);
    bus_host_i.op(4'h0, LANES_ALL, SEL_OK, a, DATA_RESET);
    @(posedge clk);
    #1 check({data_io_parity_out, data_out}, exp);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_write();
    bus_host_i.op(4'h5, LANES_ALL, SEL_OK, ADDR_A, 32'h1122_3344);
    rd(ADDR_A, word_of(32'h1122_3344));
    bus_host_i.op(4'h4, 4'he, SEL_OK, ADDR_A, 32'haabb_ccdd);
    rd(ADDR_A, {4'ha, 32'h1122_33dd});
    bus_host_i.drop_byte_enable = 1'h1;
    bus_host_i.op(4'h4, 4'h0, SEL_OK, ADDR_A, 32'h5555_5555);
    bus_host_i.drop_byte_enable = 1'h0;
    rd(ADDR_A, {4'ha, 32'h1122_33dd});
  endtask

  task automatic t_select();
    bus_host_i.op(4'hd, LANES_ALL, SEL_OK, ADDR_A, 32'h0f0f_0f0f);
    bus_host_i.op(4'h5, LANES_ALL, SEL_BAD, ADDR_A, 32'h0f0f_0f0f);
    bus_host_i.op(4'h5, LANES_ALL, 3'h3, ADDR_A, 32'h0f0f_0f0f);
    rd(ADDR_A, {4'ha, 32'h1122_33dd});
    bus_host_i.op(4'h9, LANES_ALL, 3'h6, ADDR_A, 32'h7777_8888);
    rd(ADDR_A, word_of(32'h7777_8888));
    @(negedge clk) third_sel_present = 1'h0;
    bus_host_i.op(4'h5, LANES_ALL, 3'h3, ADDR_A, 32'h2468_ace0);
    rd(ADDR_A, word_of(32'h2468_ace0));
    @(negedge clk) third_sel_present = 1'h1;
  endtask

  task automatic t_burst(input logic strap);
    logic [1:0] lo;
    @(negedge clk) burst_order_strap = strap;
    bus_host_i.op(4'h5, LANES_ALL, SEL_OK, ADDR_B, DATA_RESET);
    for (int k = 1; k < 4; k++)
      bus_host_i.op(4'h3, LANES_ALL, SEL_BAD, ADDR_B, DATA_W'(k));
    bus_host_i.op(4'h4, LANES_ALL, SEL_BAD, ADDR_A, DATA_RESET);
    bus_host_i.op(4'h0, LANES_ALL, SEL_OK, ADDR_A, DATA_RESET);
    bus_host_i.op(4'h8, LANES_ALL, SEL_OK, ADDR_B + 18'h1, DATA_RESET);
    #1 check(WORD_W'(burst_active), '0);
    for (int k = 0; k < 4; k++)
    begin
      bus_host_i.op(4'h2, LANES_ALL, SEL_OK, ADDR_B, DATA_RESET);
      @(posedge clk);
      lo = strap ? 2'h1 ^ 2'(k) : 2'h1 + 2'(k);
      #1 check({data_io_parity_out, data_out}, word_of(DATA_W'(lo)));
      check(WORD_W'(burst_active), WORD_W'(1));
      if (k < 2)
        check(WORD_W'(data_oe), WORD_W'(k));
    end
  endtask

  task automatic t_sleep();
    @(negedge clk) output_enable_n = 1'h1;
    #1 check(WORD_W'(data_oe), '0);
    @(negedge clk) {output_enable_n, sleep_request} = 2'h1;
    bus_host_i.op(4'h5, LANES_ALL, SEL_OK, ADDR_A, 32'h3333_3333);
    #1 check(WORD_W'(sleep_active), WORD_W'(1));
    // Bus goes idle before wake, so the refused write is not taken on the waking edge
    bus_host_i.op(4'h0, LANES_ALL, SEL_OK, ADDR_A, DATA_RESET);
    sleep_request = 1'h0;
    rd(ADDR_A, word_of(32'h2468_ace0));
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(negedge clk);
    reset_n = 1'h1;
    t_write();
    t_select();
    t_burst(1'h1);
    t_burst(1'h0);
    t_sleep();
    close_out();
  end

  // The whole run needs well under a hundred cycles
  initial
  begin
    repeat (400) @(posedge clk);
    fails++;
    close_out();
  end
endmodule

// file: src/burst_counter.sv
// Two-bit wrapping burst counter with linear or interleaved ordering
`timescale 1ns/10ps

module burst_counter
  import sram_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  burst_if.counter bus
);

  logic [1:0] start_q;
  logic [1:0] next_count;
  logic [1:0] next_start;

  // ------------------------------------------------------------
  // Sequence arithmetic
  // ------------------------------------------------------------
  function automatic logic [1:0] order_bits(input logic inter, input logic [1:0] base,
                                            input logic [1:0] cnt);
    // Two-bit add drops the carry, so the burst stays in its aligned group
    order_bits = inter ? (base ^ cnt) : 2'(base + cnt);
  endfunction

  always_comb
  begin
    next_start = bus.load ? bus.start_bits : start_q;
    if (bus.load)
      next_count = COUNT_RESET;
    else if (bus.advance)
      next_count = 2'(bus.count + 2'h1);
    else
      next_count = bus.count;
  end

  assign bus.next_low = order_bits(bus.interleave, next_start, next_count);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bus.count <= COUNT_RESET;
      start_q   <= COUNT_RESET;
    end
    else
    begin
      bus.count <= next_count;
      start_q   <= next_start;
    end
  end

endmodule

// file: src/burst_if.sv
// Signals between the access control and its burst address counter
`timescale 1ns/10ps

interface burst_if;
  logic       load;
  logic       advance;
  logic       interleave;
  logic [1:0] start_bits;
  logic [1:0] count;
  logic [1:0] next_low;

  modport control
  (
    output load,
    output advance,
    output interleave,
    output start_bits,
    input  count,
    input  next_low
  );

  modport counter
  (
    input  load,
    input  advance,
    input  interleave,
    input  start_bits,
    output count,
    output next_low
  );
endinterface

// file: src/pipelined_burst_sram_control.sv
// Pipelined burst SRAM: strobe decode, chip select, writes, burst and read pipeline
`timescale 1ns/10ps

module pipelined_burst_sram_control
  import sram_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [HIGH_W-1:0] addr_high,
  input  wire logic              addr_low_bit1,
  input  wire logic              addr_low_bit0,
  input  wire logic              processor_addr_strobe_n,
  input  wire logic              controller_addr_strobe_n,
  input  wire logic              burst_advance_n,
  input  wire logic              chip_sel_first_n,
  input  wire logic              chip_sel_second,
  input  wire logic              chip_sel_third_n,
  input  wire logic              third_sel_present,
  input  wire logic [LANES-1:0]  byte_lane_select_n,
  input  wire logic              byte_write_enable_n,
  input  wire logic              all_bytes_write_n,
  input  wire logic              output_enable_n,
  input  wire logic              sleep_request,
  input  wire logic              burst_order_strap,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic [LANES-1:0]  data_io_parity_in,
  output logic      [DATA_W-1:0] data_out,
  output logic      [LANES-1:0]  data_io_parity_out,
  output logic                   data_oe,
  output logic                   sleep_active,
  output logic                   burst_active
);

  burst_if bi ();

  burst_counter burst_counter_i
  (
    .clk     (clk),
    .reset_n (reset_n),
    .bus     (bi.counter)
  );

  access_state_t     state;
  logic [WORD_W-1:0] mem [0:MEM_DEPTH-1];
  logic [HIGH_W-1:0] high_q;
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] wr_addr;
  logic [WORD_W-1:0] rd_word;
  logic              rd_pending;
  logic              out_valid;
  logic              mask_stage;
  logic              drive_ok;
  logic              order_q;
  logic              chip_ok;
  logic              proc_start;
  logic              ctrl_start;
  logic              start;
  logic              accept;
  logic              cont;
  logic              wr_slot;
  logic [LANES-1:0]  wr_lanes;
  logic              wr_en;

  // ------------------------------------------------------------
  // Strobe and chip select decode
  // ------------------------------------------------------------
  // Missing third select reads as active, so two-select variants share this path
  assign chip_ok = chip_sel_second && !chip_sel_first_n
                   && (!third_sel_present || !chip_sel_third_n);
  assign proc_start = !processor_addr_strobe_n && !chip_sel_first_n;
  assign ctrl_start = !controller_addr_strobe_n && !proc_start;
  assign start  = (proc_start || ctrl_start) && !sleep_request;
  assign accept = start && chip_ok;
  // Continuation edges never check chip_ok; the first select matters only through the processor strobe
  assign cont   = (state == ST_BURST) && !start && !sleep_request;

  assign bi.load       = accept;
  assign bi.advance    = cont && !burst_advance_n;
  assign bi.interleave = order_q;
  assign bi.start_bits = {addr_low_bit1, addr_low_bit0};

  // ------------------------------------------------------------
  // Write lane decode
  // ------------------------------------------------------------
  // A processor-strobe start is always a read; its write controls come next clock
  assign wr_slot = (accept && ctrl_start) || cont;

  always_comb
  begin
    if (!all_bytes_write_n)
      wr_lanes = LANES_ALL;
    else if (!byte_write_enable_n)
      wr_lanes = ~byte_lane_select_n;
    else
      wr_lanes = LANES_NONE;
  end

  assign wr_en   = wr_slot && (wr_lanes != LANES_NONE);
  assign wr_addr = {(accept ? addr_high : high_q), bi.next_low};
  assign rd_word = mem[rd_addr];

  // ------------------------------------------------------------
  // Access state
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      state <= ST_DESEL;
    else
    begin
      case (state)
        ST_DESEL, ST_BURST:
        begin
          if (sleep_request)
            state <= ST_SLEEP;
          else if (start)
            state <= chip_ok ? ST_BURST : ST_DESEL;
        end
        ST_SLEEP:
        begin
          // A strobe on the waking edge is taken as one from deselect
          if (!sleep_request)
            state <= accept ? ST_BURST : ST_DESEL;
        end
        default:
          state <= ST_DESEL;
      endcase
    end
  end

  // Strap is sampled on every clock in deselect and held through burst and sleep
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      order_q <= 1'b1;
    else if (state == ST_DESEL)
      order_q <= burst_order_strap;
  end

  // ------------------------------------------------------------
  // Address register and memory array
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      high_q     <= '0;
      rd_addr    <= '0;
      rd_pending <= 1'b0;
    end
    else
    begin
      if (accept)
        high_q <= addr_high;
      rd_addr    <= wr_addr;
      rd_pending <= (accept || cont) && !wr_en;
    end
  end

  // Contents hold through reset and sleep
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_en && wr_lanes[i])
      begin
        mem[wr_addr][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
        mem[wr_addr][DATA_W + i]         <= data_io_parity_in[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Read pipeline and output drive
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      data_out           <= DATA_RESET;
      data_io_parity_out <= LANES_NONE;
      out_valid          <= 1'b0;
    end
    else
    begin
      out_valid <= rd_pending;
      if (rd_pending)
      begin
        data_out           <= rd_word[DATA_W-1:0];
        data_io_parity_out <= rd_word[WORD_W-1:DATA_W];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mask_stage   <= 1'b0;
      drive_ok     <= 1'b0;
      sleep_active <= 1'b0;
      burst_active <= 1'b0;
    end
    else
    begin
      mask_stage   <= accept && (state != ST_BURST) && !wr_en;
      drive_ok     <= !mask_stage && !sleep_request;
      sleep_active <= sleep_request;
      burst_active <= (state == ST_BURST);
    end
  end

  // Output enable is asynchronous, so it gates the pin directly
  assign data_oe = drive_ok && !output_enable_n;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_addr_capture: assert property (@(posedge clk) disable iff (!reset_n)
    accept |=> high_q == $past(addr_high)
               && rd_addr == {$past(addr_high), $past(bi.start_bits)})
    else $error("address not captured on accepted strobe");

  chk_select_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (start && (chip_sel_first_n || !chip_sel_second)) |=> state == ST_DESEL)
    else $error("device selected with inactive chip select");

  chk_proc_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    (!processor_addr_strobe_n && chip_sel_first_n && controller_addr_strobe_n
     && !sleep_request) |=> state == (($past(state) == ST_SLEEP) ? ST_DESEL : $past(state)))
    else $error("processor strobe acted with first select high");

  chk_strobe_priority: assert property (@(posedge clk) disable iff (!reset_n)
    (!processor_addr_strobe_n && !controller_addr_strobe_n && !chip_sel_first_n
     && !all_bytes_write_n && !sleep_request) |-> !wr_en)
    else $error("processor start treated as write");

  chk_ce_burst: assert property (@(posedge clk) disable iff (!reset_n)
    (state == ST_BURST && processor_addr_strobe_n && controller_addr_strobe_n
     && !sleep_request && !chip_sel_second) |=> state == ST_BURST)
    else $error("chip selects disturbed a running burst");

  chk_global_write: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_slot && !all_bytes_write_n) |-> wr_en && wr_lanes == LANES_ALL)
    else $error("global write missed a lane");

  chk_burst_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    (bi.advance && bi.count == 2'h3) |=> bi.count == 2'h0)
    else $error("burst counter did not wrap");

  chk_read_latency: assert property (@(posedge clk) disable iff (!reset_n)
    rd_pending |=> out_valid && data_out == $past(rd_word[DATA_W-1:0]))
    else $error("read data not one clock after address");

  chk_first_mask: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && state == ST_DESEL && !wr_en) |=> ##1 !data_oe)
    else $error("output driven on first read clock after deselect");

  chk_sleep_idle: assert property (@(posedge clk) disable iff (!reset_n)
    sleep_request |=> state == ST_SLEEP && !data_oe && sleep_active)
    else $error("sleep did not idle the device");

endmodule

// file: src/sram_ctrl_pkg.sv
// Constants and types shared by the pipelined burst SRAM control logic
package sram_ctrl_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int ADDR_W    = 18;
  localparam int HIGH_W    = ADDR_W - 2;
  localparam int LANES     = 4;
  localparam int LANE_W    = 8;
  localparam int DATA_W    = LANES * LANE_W;
  localparam int WORD_W    = DATA_W + LANES;
  localparam int MEM_DEPTH = 1 << ADDR_W;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [1:0]        COUNT_RESET = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RESET  = 32'h0000_0000;
  localparam logic [LANES-1:0]  LANES_NONE  = 4'h0;
  localparam logic [LANES-1:0]  LANES_ALL   = 4'hf;

  // ------------------------------------------------------------
  // Access state
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_DESEL = 3'b001,
    ST_BURST = 3'b010,
    ST_SLEEP = 3'b100
  } access_state_t;

endpackage
